// *** include/drpr_pkg.sv ***
// constants for the third-reference profile register bank
package drpr_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // byte addresses of the bank
   localparam logic [11:0] OFS_BW_B0    = 12'h45B;
   localparam logic [11:0] OFS_BW_B1    = 12'h45C;
   localparam logic [11:0] OFS_BW_B2    = 12'h45D;
   localparam logic [11:0] OFS_INT_B0   = 12'h45E;
   localparam logic [11:0] OFS_INT_B1   = 12'h45F;
   localparam logic [11:0] OFS_INT_B2   = 12'h460;
   localparam logic [11:0] OFS_NUM_B0   = 12'h461;
   localparam logic [11:0] OFS_NUM_B1   = 12'h462;
   localparam logic [11:0] OFS_NUM_B2   = 12'h463;
   localparam logic [11:0] OFS_DEN_B0   = 12'h464;
   localparam logic [11:0] OFS_DEN_B1   = 12'h465;
   localparam logic [11:0] OFS_DEN_B2   = 12'h466;
   localparam logic [11:0] OFS_REF_CTRL = 12'h45A;
   localparam logic [11:0] OFS_STATUS   = 12'h467;

   // field positions
   localparam int BW_TOP_BIT     = 0;
   localparam int FILTER_SEL_BIT = 1;
   localparam int REF_EN_BIT     = 0;

   // widths of assembled values
   localparam int BW_W   = 17;
   localparam int INT_W  = 18;
   localparam int FRAC_W = 24;

   // reset values
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [7:0] RST_REF_CTRL = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // bandwidth count unit, in tenths of a hertz
   localparam int BW_UNIT_DHZ = 1;
endpackage

// *** rtl/drpr_byte_reg.sv ***
// one byte-wide storage register with write mask and reset
`timescale 1ns/1ps
module drpr_byte_reg #(
   parameter logic [7:0] WR_MASK  = 8'hFF,
   parameter logic [7:0] RST_VAL  = 8'h00
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // write side
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // stored value
   output logic [7:0]      q
);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= RST_VAL;
      end else if (wr_en) begin
         // reserved bits stay zero
         q <= wr_data & WR_MASK;
      end
   end
endmodule

// *** rtl/drpr_regs.sv ***
// third-reference profile register bank for the first digital loop
//
// Contract
// - 17-bit bandwidth from three bytes, 0.1 Hz units
// - bandwidth bytes reset to zero
// - bit 1 of third byte selects filter
// - 18-bit integer divider stored minus one
// - integer divider bytes reset to zero
// - 24-bit numerator, low byte lowest address
// - 24-bit denominator, low byte lowest address
// - profile applied only when reference enabled
`timescale 1ns/1ps
module drpr_regs
   import drpr_pkg::*;
(
   // clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   // register port
   input  wire logic [drpr_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [drpr_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic [drpr_pkg::DATA_W-1:0]        reg_rdata,
   // profile to the loop core
   output logic                               profile_active,
   output logic [drpr_pkg::BW_W-1:0]          loop_bw_scale,
   output logic                               high_margin_filter,
   output logic [drpr_pkg::INT_W-1:0]         integer_feedback_count,
   output logic [drpr_pkg::INT_W:0]           int_divide_ratio,
   output logic [drpr_pkg::FRAC_W-1:0]        fractional_numerator,
   output logic [drpr_pkg::FRAC_W-1:0]        fractional_denominator,
   output logic                               frac_in_use
);
   import drpr_pkg::*;

   localparam int NREG = 13;

   // byte order of the bank: 12 profile bytes then the enable byte
   localparam logic [NREG*12-1:0] ADDR_TABLE = {
      OFS_REF_CTRL,
      OFS_DEN_B2, OFS_DEN_B1, OFS_DEN_B0,
      OFS_NUM_B2, OFS_NUM_B1, OFS_NUM_B0,
      OFS_INT_B2, OFS_INT_B1, OFS_INT_B0,
      OFS_BW_B2,  OFS_BW_B1,  OFS_BW_B0
   };

   // writable bits per byte; the rest are reserved and read zero
   localparam logic [NREG*8-1:0] MASK_TABLE = {
      8'h01,
      8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF,
      8'h03, 8'hFF, 8'hFF,
      8'h03, 8'hFF, 8'hFF
   };

   // address compare and byte lanes are fixed at these widths
   if (ADDR_W < 12 || DATA_W != 8) begin : g_bad_width
      $error("drpr_regs: bank needs 12-bit address and 8-bit data");
   end

   logic [NREG-1:0]   hit;
   logic [NREG-1:0]   wr_sel;
   logic [NREG*8-1:0] q_flat;
   logic [7:0]        q [NREG];

   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_byte
         assign hit[gi]    = (reg_addr[11:0] == ADDR_TABLE[gi*12 +: 12]);
         assign wr_sel[gi] = reg_wr & hit[gi];
         // profile bytes and the enable all come out of reset at zero
         drpr_byte_reg #(
            .WR_MASK (MASK_TABLE[gi*8 +: 8]),
            .RST_VAL ((gi == NREG-1) ? RST_REF_CTRL : RST_BYTE)
         ) u_byte (
            .core_clk (core_clk),
            .rst      (rst),
            .wr_en    (wr_sel[gi]),
            .wr_data  (reg_wdata),
            .q        (q[gi])
         );
         assign q_flat[gi*8 +: 8] = q[gi];
      end
   endgenerate

   // field assembly
   wire logic [BW_W-1:0]   bw_word;
   wire logic              filt_sel;
   wire logic [INT_W-1:0]  int_word;
   wire logic [FRAC_W-1:0] num_word;
   wire logic [FRAC_W-1:0] den_word;
   wire logic              ref_enable;

   assign bw_word    = {q[2][BW_TOP_BIT], q[1], q[0]};
   assign filt_sel   = q[2][FILTER_SEL_BIT];
   assign int_word   = {q[5][1:0], q[4], q[3]};
   assign num_word   = {q[8], q[7], q[6]};
   assign den_word   = {q[11], q[10], q[9]};
   assign ref_enable = q[12][REF_EN_BIT];

   // stored value is ratio minus one, so the true ratio needs one more bit
   wire logic [INT_W:0]    ratio_word;
   wire logic              den_nonzero;
   assign ratio_word  = {1'b0, int_word} + {{INT_W{1'b0}}, 1'b1};
   assign den_nonzero = (den_word != '0);

   // read decode
   wire logic              status_hit;
   wire logic [7:0]        status_byte;
   logic [7:0]             bank_rd;
   assign status_hit  = (reg_addr[11:0] == OFS_STATUS);
   assign status_byte = {5'h00, den_nonzero, filt_sel, profile_active};

   always_comb begin
      bank_rd = READ_UNMAPPED;
      for (int i = 0; i < NREG; i++) begin
         if (hit[i]) begin
            bank_rd = q_flat[i*8 +: 8];
         end
      end
      if (status_hit) begin
         bank_rd = status_byte;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= READ_UNMAPPED;
      end else if (reg_rd) begin
         reg_rdata <= bank_rd;
      end else begin
         reg_rdata <= READ_UNMAPPED;
      end
   end

   // outputs are registered; a disabled reference presents a zero profile
   // so the loop sees nothing while disabled; bytes written while enabled reach it one at a time
   always_ff @(posedge core_clk) begin
      if (rst) begin
         profile_active         <= 1'b0;
         loop_bw_scale          <= '0;
         high_margin_filter     <= 1'b0;
         integer_feedback_count <= '0;
         int_divide_ratio       <= '0;
         fractional_numerator   <= '0;
         fractional_denominator <= '0;
         frac_in_use            <= 1'b0;
      end else if (ref_enable) begin
         profile_active         <= 1'b1;
         loop_bw_scale          <= bw_word;
         high_margin_filter     <= filt_sel;
         integer_feedback_count <= int_word;
         int_divide_ratio       <= ratio_word;
         fractional_numerator   <= den_nonzero ? num_word : '0;
         fractional_denominator <= den_word;
         frac_in_use            <= den_nonzero;
      end else begin
         profile_active         <= 1'b0;
         loop_bw_scale          <= '0;
         high_margin_filter     <= 1'b0;
         integer_feedback_count <= '0;
         int_divide_ratio       <= '0;
         fractional_numerator   <= '0;
         fractional_denominator <= '0;
         frac_in_use            <= 1'b0;
      end
   end
endmodule

// *** bench/drpr_regs_sva.sv ***
// port checker of the third-reference profile bank
`timescale 1ns/1ps
module drpr_regs_chk
   import drpr_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // profile outputs
   input wire logic        profile_active,
   input wire logic [16:0] loop_bw_scale,
   input wire logic        high_margin_filter,
   input wire logic [17:0] integer_feedback_count,
   input wire logic [18:0] int_divide_ratio,
   input wire logic [23:0] fractional_numerator,
   input wire logic [23:0] fractional_denominator,
   input wire logic        frac_in_use
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // byte written once, then the loop still enabled when the output lands
   sequence wr_s(a);
      reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a) ##1 profile_active;
   endsequence
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
   bw_low_a: assert property (wr_s(OFS_BW_B0) |-> loop_bw_scale[7:0] == $past(reg_wdata, 2))
      else $error("bandwidth low byte wrong");
   bw_top_a: assert property (wr_s(OFS_BW_B2) |-> loop_bw_scale[16] == $past(reg_wdata[0], 2))
      else $error("bandwidth top bit wrong");
   filt_sel_a: assert property (wr_s(OFS_BW_B2) |-> high_margin_filter == $past(reg_wdata[1], 2))
      else $error("filter select wrong");
   int_top_a: assert property (wr_s(OFS_INT_B2) |-> integer_feedback_count[17:16] == $past(reg_wdata[1:0], 2))
      else $error("integer top bits wrong");
   num_top_a: assert property (wr_s(OFS_NUM_B2) ##0 frac_in_use |-> fractional_numerator[23:16] == $past(reg_wdata, 2))
      else $error("numerator top byte wrong");
   den_low_a: assert property (wr_s(OFS_DEN_B0) |-> fractional_denominator[7:0] == $past(reg_wdata, 2))
      else $error("denominator low byte wrong");
   div_ratio_a: assert property (profile_active |-> int_divide_ratio == integer_feedback_count + 19'h1)
      else $error("divide ratio not stored plus one");
   frac_use_a: assert property (frac_in_use == (profile_active && fractional_denominator != 24'h0))
      else $error("fraction use flag wrong");
   off_zero_a: assert property (!profile_active |-> loop_bw_scale == 17'h0 && !high_margin_filter)
      else $error("profile applied while disabled");
   num_zero_a: assert property (!frac_in_use |-> fractional_numerator == 24'h0)
      else $error("numerator kept without fraction");
endmodule

// *** bench/tb_drpr_regs.sv ***
// self-checking bench of the third-reference profile bank
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_drpr_regs;
   import drpr_pkg::*;
   logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, profile_active, high_margin_filter, frac_in_use;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic [16:0] loop_bw_scale;
   logic [17:0] integer_feedback_count;
   logic [18:0] int_divide_ratio;
   logic [23:0] fractional_numerator, fractional_denominator;
   logic [31:0] lf = 32'h830E;
   logic [7:0]  m [12'h45A:12'h466];
   int          n_mismatch = 0, checks = 0;
   drpr_regs drpr_regs_inst (
      .core_clk               (core_clk),
      .rst                    (rst),
      .reg_addr               (reg_addr),
      .reg_wdata              (reg_wdata),
      .reg_wr                 (reg_wr),
      .reg_rd                 (reg_rd),
      .reg_rdata              (reg_rdata),
      .profile_active         (profile_active),
      .loop_bw_scale          (loop_bw_scale),
      .high_margin_filter     (high_margin_filter),
      .integer_feedback_count (integer_feedback_count),
      .int_divide_ratio       (int_divide_ratio),
      .fractional_numerator   (fractional_numerator),
      .fractional_denominator (fractional_denominator),
      .frac_in_use            (frac_in_use)
   );
   function automatic logic [7:0] lfsr();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[7:0];
   endfunction
   // status is also read while disabled; its filter and denominator bits are ungated, as in the bank
   function automatic logic [7:0] want(logic [11:0] a);
      if (a == OFS_STATUS) return {5'h0, (m[12'h464] | m[12'h465] | m[12'h466]) != 8'h00, m[12'h45D][1], m[12'h45A][0]};
      return (a >= OFS_REF_CTRL && a <= OFS_DEN_B2) ? m[a] : READ_UNMAPPED;
   endfunction
   task automatic wr(logic [11:0] a, logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1;
      reg_rd <= 0;
      reg_addr <= a;
      reg_wdata <= d;
      if (a >= OFS_REF_CTRL && a <= OFS_DEN_B2)
         m[a] = d & (a == OFS_BW_B2 || a == OFS_INT_B2 ? 8'h03 : a == OFS_REF_CTRL ? 8'h01 : 8'hFF);
   endtask
   task automatic rd(logic [11:0] a);
      @(posedge core_clk);
      reg_wr <= 0;
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 0;
      #1 `CHK(reg_rdata, want(a))
   endtask
   task automatic outs();
      logic        en;
      logic [23:0] den;
      @(posedge core_clk);
      reg_wr <= 0;
      repeat (2) @(posedge core_clk);
      #1 en = m[12'h45A][0];
      den = {m[12'h466], m[12'h465], m[12'h464]};
      `CHK(profile_active, en)
      `CHK(loop_bw_scale, en ? {m[12'h45D][0], m[12'h45C], m[12'h45B]} : 17'h0)
      `CHK(high_margin_filter, en & m[12'h45D][1])
      `CHK(int_divide_ratio, en ? {1'b0, m[12'h460][1:0], m[12'h45F], m[12'h45E]} + 19'h1 : 19'h0)
      `CHK(integer_feedback_count, en ? {m[12'h460][1:0], m[12'h45F], m[12'h45E]} : 18'h0)
      `CHK(frac_in_use, en && den != 0)
      `CHK(fractional_denominator, en ? den : 24'h0)
      `CHK(fractional_numerator, en && den != 0 ? {m[12'h463], m[12'h462], m[12'h461]} : 24'h0)
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end
   initial begin
      for (int r = 0; r < 2; r++) begin
         @(posedge core_clk);
         rst <= 1;
         repeat (6) @(posedge core_clk);
         rst <= 0;
         foreach (m[i]) m[i] = 8'h00;
         for (int a = 'h458; a < 'h469; a++) rd(12'(a));
         // random traffic covers reserved bits, status and unmapped writes
         for (int k = 0; k < 48; k++) begin
            wr(12'h45A + lfsr() % 16, lfsr());
            if (k % 8 == 7) outs();
         end
         wr(OFS_REF_CTRL, 8'hFF);
         wr(OFS_DEN_B0, 8'h00);
         wr(OFS_DEN_B1, 8'h00);
         wr(OFS_DEN_B2, 8'h00);
         outs();
         wr(OFS_DEN_B1, 8'h80);
         // 3 kHz setting: above the crystal floor, below detector rate/20
         wr(OFS_BW_B0, 8'h30);
         wr(OFS_BW_B1, 8'h75);
         // above 2 kHz the high margin filter is chosen
         wr(OFS_BW_B2, 8'h02);
         outs();
         for (int a = 'h458; a < 'h469; a++) rd(12'(a));
      end
      close_out();
   end
endmodule
bind drpr_regs drpr_regs_chk drpr_regs_chk_inst (
   .core_clk               (core_clk),
   .rst                    (rst),
   .reg_addr               (reg_addr),
   .reg_wdata              (reg_wdata),
   .reg_wr                 (reg_wr),
   .reg_rd                 (reg_rd),
   .reg_rdata              (reg_rdata),
   .profile_active         (profile_active),
   .loop_bw_scale          (loop_bw_scale),
   .high_margin_filter     (high_margin_filter),
   .integer_feedback_count (integer_feedback_count),
   .int_divide_ratio       (int_divide_ratio),
   .fractional_numerator   (fractional_numerator),
   .fractional_denominator (fractional_denominator),
   .frac_in_use            (frac_in_use)
);
